/* include/ssr_pkg.sv */
// Constants and types shared by the SRAM scan register set
package ssr_pkg;
    // Scan path lengths and update FIFO depth
    localparam int IR_LEN   = 3;
    localparam int ID_LEN   = 32;
    localparam int BND_LEN  = 109;
    localparam int FIFO_DEPTH = 4;

    // Identification word fields
    localparam int ID_REV_MSB  = 31;
    localparam int ID_REV_LSB  = 28;
    localparam int ID_PART_MSB = 27;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_MSB  = 11;
    localparam int ID_MFR_LSB  = 1;
    localparam logic ID_FIX_BIT = 1'b1;

    // Values arbitrary, stand-ins for the real identification codes
    localparam logic [3:0]  ID_REVISION = 4'h1;
    localparam logic [15:0] ID_PART_X9  = 16'h0a01;
    localparam logic [15:0] ID_PART_X18 = 16'h0a02;
    localparam logic [15:0] ID_PART_X36 = 16'h0a03;
    localparam logic [10:0] ID_MFR      = 11'h055;

    // Instruction codes
    localparam logic [2:0] INS_EXTEST  = 3'h0;
    localparam logic [2:0] INS_IDCODE  = 3'h1;
    localparam logic [2:0] INS_SAMPLEZ = 3'h2;
    localparam logic [2:0] INS_SAMPLE  = 3'h4;
    localparam logic [2:0] INS_BYPASS  = 3'h7;
    localparam logic [2:0] IR_CAPTURE  = 3'h1;

    // Mode select highs that force test-logic-reset
    localparam int TMS_RESET_EDGES = 5;

    typedef enum logic [1:0] {
        ORG_X9  = 2'h0,
        ORG_X18 = 2'h1,
        ORG_X36 = 2'h2
    } ssr_org_t;

    typedef enum logic [3:0] {
        ST_RESET   = 4'h0,
        ST_IDLE    = 4'h1,
        ST_SEL_DR  = 4'h3,
        ST_CAP_DR  = 4'h2,
        ST_SH_DR   = 4'h6,
        ST_EX1_DR  = 4'h7,
        ST_PAU_DR  = 4'h5,
        ST_EX2_DR  = 4'h4,
        ST_UPD_DR  = 4'hc,
        ST_SEL_IR  = 4'hd,
        ST_CAP_IR  = 4'hf,
        ST_SH_IR   = 4'he,
        ST_EX1_IR  = 4'ha,
        ST_PAU_IR  = 4'hb,
        ST_EX2_IR  = 4'h9,
        ST_UPD_IR  = 4'h8
    } ssr_tap_t;
endpackage

/* design/ssr_fifo.sv */
// Parameterised word FIFO with valid/ready on both sides
`timescale 1ns/1ns
module ssr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_q;
    logic [AW:0]      rdPtr_q;
    logic             doWr;
    logic             doRd;

    assign inReady  = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_q != rdPtr_q;
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;
    assign outData  = mem[rdPtr_q[AW-1:0]];

    always_ff @(posedge clk_sys)
    begin
        if (doWr)
        begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end
        else
        begin
            if (doWr)
            begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doRd)
            begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule // ssr_fifo

/* design/ssr_scan.sv */
// Scan registers, test port controller and update hand-off of the SRAM
// Function
// - Instruction 3, bypass 1, identification 32, boundary 109 bits between data in and out.
// - Identification holds revision in [31:28], width-dependent part number in [27:12].
// - Identification holds manufacturer code in [11:1], bit 0 constant one.
// - Cell 48 captures low in the widest organization.
// - Cell 64 captures low in the two wider organizations.
// - Cells on supply or unconnected bumps capture low regardless of wiring.
// - Identification instruction loads the code on capture, shifts it out on shift.
// - Boundary register captures the pad ring on capture, shifts on shift.
// - Test data output changes only on the falling test clock edge.
// - Five rising edges with mode select high enter test-logic-reset.
`timescale 1ns/1ns
module ssr_scan
    import ssr_pkg::*;
(
    // System side
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    // Test port
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    output logic                    tdo,
    output logic                    tdoEn,
    // Pad ring and width strap
    input  wire logic [BND_LEN-1:0] padRing,
    input  wire logic [1:0]         orgSel,
    output logic                    qForceOff,
    // Boundary update words towards the pad drivers
    output logic                    updValid,
    input  wire logic               updReady,
    output logic [BND_LEN-1:0]      updData
);
    // Used-cell test per position, 1-based as numbered on the ring
    function automatic logic cellUsed(input int pos, input logic [1:0] org);
        logic used;
        used = 1'b1;
        if (pos inside {54, 109})
        begin
            used = 1'b0;
        end
        else if (pos == 64)
        begin
            used = (org == ORG_X9);
        end
        else if (pos == 48)
        begin
            used = (org != ORG_X36);
        end
        else if (pos inside {12, 13, 16, 17, 20, 21, 24, 25, 29, 30, 33, 34, 37, 38,
                             41, 42, 45, 46, 58, 68, 69, 72, 73, 76, 77, 80, 81, 85,
                             86, 89, 90, 93, 94, 97, 98, 101, 102})
        begin
            used = (org == ORG_X36);
        end
        else if (pos inside {14, 15, 22, 23, 31, 32, 39, 40, 59, 66, 67, 70, 71, 78,
                             79, 87, 88, 95, 96})
        begin
            used = (org != ORG_X9);
        end
        return used;
    endfunction

    function automatic logic [15:0] partNumber(input logic [1:0] org);
        logic [15:0] pn;
        pn = ID_PART_X36;
        if (org == ORG_X9)
        begin
            pn = ID_PART_X9;
        end
        else if (org == ORG_X18)
        begin
            pn = ID_PART_X18;
        end
        return pn;
    endfunction

    // Test clock domain
    ssr_tap_t           tap_q;
    ssr_tap_t           tap_d;
    logic [1:0]         rstSync_q;
    logic [1:0]         org1_q;
    logic [1:0]         org2_q;
    logic [BND_LEN-1:0] pad1_q;
    logic [BND_LEN-1:0] pad2_q;
    logic [BND_LEN-1:0] cellMask;
    logic [IR_LEN-1:0]  irShift_q;
    logic [IR_LEN-1:0]  ir_q;
    logic               bypass_q;
    logic [ID_LEN-1:0]  idShift_q;
    logic [BND_LEN-1:0] bnd_q;
    logic [BND_LEN-1:0] updWord_q;
    logic               reqTgl_q;
    logic [1:0]         ackSync_q;
    logic               ackTgl_q;
    logic               busy;
    logic               serialOut;
    logic [ID_LEN-1:0]  idWord;
    logic               bndSel;
    logic               tapReset;

    // Power-up style reset carried in from the system reset
    always_ff @(posedge tck)
    begin
        rstSync_q <= {rstSync_q[0], ~rst_b};
    end
    assign tapReset = rstSync_q[1];

    // Pins sampled twice before use; capture still needs a stable ring
    always_ff @(posedge tck)
    begin
        pad1_q <= padRing;
        pad2_q <= pad1_q;
        org1_q <= orgSel;
        org2_q <= org1_q;
    end

    always_comb
    begin
        for (int i = 0; i < BND_LEN; i++)
        begin
            // supply and unconnected cells read low
            cellMask[i] = cellUsed(i + 1, org2_q);
        end
    end

    assign idWord = {ID_REVISION, partNumber(org2_q), ID_MFR, ID_FIX_BIT};

    // mode select high walks any state into reset within five edges
    always_comb
    begin
        tap_d = tap_q;
        case (tap_q)
            ST_RESET:  tap_d = tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   tap_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: tap_d = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_d = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  tap_d = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_d = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: tap_d = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: tap_d = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: tap_d = tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: tap_d = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  tap_d = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_d = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: tap_d = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: tap_d = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_d = tms ? ST_SEL_DR : ST_IDLE;
            default:   tap_d = ST_RESET;
        endcase
    end

    always_ff @(posedge tck)
    begin
        if (tapReset)
        begin
            tap_q <= ST_RESET;
        end
        else
        begin
            tap_q <= tap_d;
        end
    end

    // instruction shift path, identification selected after reset
    always_ff @(posedge tck)
    begin
        if (tapReset || tap_q == ST_RESET)
        begin
            irShift_q <= IR_CAPTURE;
            ir_q      <= INS_IDCODE;
        end
        else if (tap_q == ST_CAP_IR)
        begin
            irShift_q <= IR_CAPTURE;
        end
        else if (tap_q == ST_SH_IR)
        begin
            irShift_q <= {tdi, irShift_q[IR_LEN-1:1]};
        end
        else if (tap_q == ST_UPD_IR)
        begin
            ir_q <= irShift_q;
        end
    end

    // Reserved codes fall back to bypass
    assign bndSel = ir_q inside {INS_EXTEST, INS_SAMPLEZ, INS_SAMPLE};

    always_ff @(posedge tck)
    begin
        if (tap_q == ST_CAP_DR)
        begin
            bypass_q <= 1'b0;
        end
        else if (tap_q == ST_SH_DR)
        begin
            bypass_q <= tdi;
        end
    end

    always_ff @(posedge tck)
    begin
        // Also loaded in reset, so tdo is not unknown while idle with identification selected
        if ((tap_q == ST_CAP_DR && ir_q == INS_IDCODE) || tap_q == ST_RESET)
        begin
            idShift_q <= idWord;
        end
        else if (tap_q == ST_SH_DR && ir_q == INS_IDCODE)
        begin
            idShift_q <= {tdi, idShift_q[ID_LEN-1:1]};
        end
    end

    // pad ring capture, cell 1 nearest the output
    always_ff @(posedge tck)
    begin
        if (tap_q == ST_CAP_DR && bndSel)
        begin
            bnd_q <= pad2_q & cellMask;
        end
        else if (tap_q == ST_SH_DR && bndSel)
        begin
            bnd_q <= {tdi, bnd_q[BND_LEN-1:1]};
        end
    end

    always_comb
    begin
        serialOut = bypass_q;
        if (tap_q == ST_SH_IR)
        begin
            serialOut = irShift_q[0];
        end
        else if (ir_q == INS_IDCODE)
        begin
            serialOut = idShift_q[0];
        end
        else if (bndSel)
        begin
            serialOut = bnd_q[0];
        end
    end

    // output moves on the falling edge only
    always_ff @(negedge tck)
    begin
        tdo   <= serialOut;
        tdoEn <= (tap_q == ST_SH_DR) || (tap_q == ST_SH_IR);
    end

    // Data pins held off while the high-impedance sample is loaded
    always_ff @(posedge tck)
    begin
        if (tapReset || tap_q == ST_RESET)
        begin
            qForceOff <= 1'b0;
        end
        else if (tap_q == ST_UPD_IR)
        begin
            qForceOff <= (irShift_q == INS_SAMPLEZ);
        end
    end

    // Update word hand-off; an update while one is pending is dropped
    assign busy = reqTgl_q != ackSync_q[1];

    always_ff @(posedge tck)
    begin
        ackSync_q <= {ackSync_q[0], ackTgl_q};
        if (tapReset)
        begin
            reqTgl_q <= 1'b0;
        end
        else if (tap_q == ST_UPD_DR && bndSel && !busy)
        begin
            updWord_q <= bnd_q;
            reqTgl_q  <= ~reqTgl_q;
        end
    end

    // System clock domain
    logic [1:0] reqSync_q;
    logic       pending;
    logic       fifoInReady;

    assign pending = reqSync_q[1] != ackTgl_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            reqSync_q <= 2'h0;
            ackTgl_q  <= 1'b0;
        end
        else
        begin
            reqSync_q <= {reqSync_q[0], reqTgl_q};
            // Word stays still while unacknowledged, so it is safe to sample
            if (pending && fifoInReady)
            begin
                ackTgl_q <= ~ackTgl_q;
            end
        end
    end

    ssr_fifo #(
        .WIDTH (BND_LEN),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .inValid  (pending),
        .inReady  (fifoInReady),
        .inData   (updWord_q),
        .outValid (updValid),
        .outReady (updReady),
        .outData  (updData)
    );
endmodule // ssr_scan

/* testbench/ssr_jtag_ctrl.sv */
// Board test controller model driving the serial test port
`timescale 1ns/1ns
module ssr_jtag_ctrl
    import ssr_pkg::*;
(
    // Test port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // Clock only runs inside frames; tdo read at the rising edge
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3 tck = 1'b1;
        q = tdo;
        #3 tck = 1'b0;
    endtask

    task automatic go_reset(input int n);
        logic q;
        repeat (n) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask

    // From idle through one shift frame back to idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, 1'b0, q);
        if (ir)
            tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        // Idle data line must not look like the last bit
        tdi = ~tdi;
    endtask
endmodule // ssr_jtag_ctrl

/* testbench/ssr_scan_checker.sv */
// Port-level assertions for the scan register block
`timescale 1ns/1ns
module ssr_scan_checker
    import ssr_pkg::*;
(
    // Clocks and reset
    input wire logic               clk_sys,
    input wire logic               rst_b,
    input wire logic               tck,
    // Test port
    input wire logic               tms,
    input wire logic               tdo,
    input wire logic               tdoEn,
    // Update stream
    input wire logic               updValid,
    input wire logic               updReady,
    input wire logic [BND_LEN-1:0] updData
);
    sequence s_five_high;
        tms [*5];
    endsequence
    sequence s_stall;
        updValid && !updReady;
    endsequence

    // Sampled tck high means this event is a falling edge
    property p_tdo_fall;
        @(edge tck) disable iff (!rst_b) tck |-> $stable(tdo);
    endproperty
    property p_en_fall;
        @(edge tck) disable iff (!rst_b) tck |-> $stable(tdoEn);
    endproperty
    property p_tms_reset;
        @(posedge tck) disable iff (!rst_b) s_five_high |=> !tdoEn;
    endproperty
    property p_shift_entry;
        @(posedge tck) disable iff (!rst_b) $rose(tdoEn) |-> !$past(tms);
    endproperty
    property p_shift_exit;
        @(posedge tck) disable iff (!rst_b) $fell(tdoEn) |-> $past(tms);
    endproperty
    property p_upd_hold;
        @(posedge clk_sys) disable iff (!rst_b) s_stall |=> updValid;
    endproperty
    property p_upd_data;
        @(posedge clk_sys) disable iff (!rst_b) s_stall |=> $stable(updData);
    endproperty
    property p_upd_reset;
        @(posedge clk_sys) disable iff (!rst_b) $rose(rst_b) |-> !updValid ##1 !updValid;
    endproperty

    a_tdo_fall: assert property (p_tdo_fall)
        else $error("tdo moved on a rising test clock edge");
    a_en_fall: assert property (p_en_fall)
        else $error("tdo enable moved on a rising test clock edge");
    a_tms_reset: assert property (p_tms_reset)
        else $error("five mode select highs left a shift active");
    a_shift_entry: assert property (p_shift_entry)
        else $error("shift entered without mode select low");
    a_shift_exit: assert property (p_shift_exit)
        else $error("shift left without mode select high");
    a_upd_hold: assert property (p_upd_hold)
        else $error("update word dropped before acceptance");
    a_upd_data: assert property (p_upd_data)
        else $error("update word changed while stalled");
    a_upd_reset: assert property (p_upd_reset)
        else $error("update valid after reset");
endmodule // ssr_scan_checker

bind ssr_scan ssr_scan_checker u_chk (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .tck      (tck),
    .tms      (tms),
    .tdo      (tdo),
    .tdoEn    (tdoEn),
    .updValid (updValid),
    .updReady (updReady),
    .updData  (updData)
);

/* testbench/ssr_scan_register_set_test.sv */
// Self-checking bench for the scan register block
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module ssr_scan_register_set_test
    import ssr_pkg::*;
;
    logic               clk_sys;
    logic               rst_b;
    logic               tck;
    logic               tms;
    logic               tdi;
    logic               tdo;
    logic               tdoEn;
    logic               qForceOff;
    logic               updValid;
    logic               updReady;
    logic [BND_LEN-1:0] padRing;
    logic [BND_LEN-1:0] updData;
    logic [1:0]         orgSel;
    logic [BND_LEN-1:0] expQ[$];
    int                 num_errors = 0;
    int                 checks = 0;

    always #10 clk_sys = ~clk_sys;

    ssr_jtag_ctrl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    ssr_scan dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdoEn(tdoEn), .padRing(padRing), .orgSel(orgSel),
        .qForceOff(qForceOff), .updValid(updValid), .updReady(updReady),
        .updData(updData)
    );

    function automatic logic [BND_LEN-1:0] low_mask(input ssr_org_t org);
        byte p18[18] = '{12, 16, 20, 24, 29, 33, 37, 41, 45, 68, 72, 76, 80, 85, 89, 93, 97, 101};
        byte p9[9] = '{14, 22, 31, 39, 66, 70, 78, 87, 95};
        logic [BND_LEN-1:0] m;
        m = '0;
        m[53] = 1'b1;
        m[108] = 1'b1;
        m[47] = org == ORG_X36;
        m[63] = org != ORG_X9;
        m[58] = org == ORG_X9;
        m[57] = org != ORG_X36;
        foreach (p18[i])
            if (org != ORG_X36)
                m[p18[i] - 1 +: 2] = 2'h3;
        foreach (p9[i])
            if (org == ORG_X9)
                m[p9[i] - 1 +: 2] = 2'h3;
        return m;
    endfunction

    task automatic set_org(input ssr_org_t org, input int k);
        @(posedge clk_sys);
        orgSel <= org;
        for (int i = 0; i < BND_LEN; i++)
            padRing[i] <= ((i + k) % 3) != 0;
        @(posedge clk_sys);
    endtask

    task automatic t_ident(input ssr_org_t org);
        logic [127:0] q;
        logic [31:0]  id;
        id = {ID_REVISION, (org == ORG_X9) ? ID_PART_X9 :
              ((org == ORG_X18) ? ID_PART_X18 : ID_PART_X36), ID_MFR, ID_FIX_BIT};
        set_org(org, 0);
        ctl.go_reset(8);
        ctl.scan(1'b0, 33, 128'h1, q);
        `CHK(q[31:0], id)
        `CHK(q[32], 1'b1)
        ctl.scan(1'b1, 4, 128'h3, q);
        `CHK(q[3:0], {1'b1, IR_CAPTURE})
        ctl.scan(1'b0, 32, 128'h0, q);
        `CHK(q[31:0], id)
    endtask

    task automatic t_bypass();
        logic [127:0] q;
        logic [2:0]   codes[4] = '{INS_BYPASS, 3'h3, 3'h5, 3'h6};
        foreach (codes[i])
        begin
            ctl.scan(1'b1, 3, 128'(codes[i]), q);
            ctl.scan(1'b0, 3, 128'h6, q);
            `CHK(q[2:1], 2'h2)
        end
        ctl.scan(1'b1, 3, 128'(INS_SAMPLEZ), q);
        `CHK(qForceOff, 1'b1)
        ctl.go_reset(5);
        `CHK(qForceOff, 1'b0)
    endtask

    // Consumer stalls, so every update word queues up
    task automatic t_bound(input ssr_org_t org, input int k, input logic [2:0] ins);
        logic [127:0] q;
        logic [127:0] d;
        set_org(org, k);
        d = {4{32'h9e3779b9}} << k;
        ctl.scan(1'b1, 3, 128'(ins), q);
        ctl.scan(1'b0, BND_LEN + 1, d, q);
        `CHK(q[BND_LEN-1:0], padRing & ~low_mask(org))
        `CHK(q[BND_LEN], d[0])
        expQ.push_back(d[BND_LEN:1]);
    endtask

    task automatic t_drain();
        logic [BND_LEN-1:0] w;
        int                 n;
        while (expQ.size() > 0)
        begin
            w = expQ.pop_front();
            n = 0;
            do
                @(negedge clk_sys);
            while (updValid !== 1'b1 && ++n < 100);
            `CHK(updData, w)
            @(posedge clk_sys) updReady <= 1'b1;
            @(posedge clk_sys) updReady <= 1'b0;
        end
        @(negedge clk_sys);
        `CHK(updValid, 1'b0)
    endtask

    task automatic end_of_test();
        $display("mismatches %0d of %0d comparisons", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #100000;
        num_errors++;
        end_of_test();
    end

    initial
    begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        padRing = '0;
        orgSel = 2'h0;
        updReady = 1'b0;
        repeat (20) @(posedge clk_sys);
        ctl.go_reset(4);
        @(posedge clk_sys) rst_b <= 1'b1;
        t_ident(ORG_X9);
        t_ident(ORG_X18);
        t_ident(ORG_X36);
        t_bypass();
        t_bound(ORG_X9, 0, INS_SAMPLE);
        t_bound(ORG_X18, 1, INS_SAMPLE);
        t_bound(ORG_X36, 2, INS_SAMPLE);
        t_bound(ORG_X36, 3, INS_EXTEST);
        t_drain();
        end_of_test();
    end
endmodule // ssr_scan_register_set_test
